// ===== core/swp_timing.sv
// Purpose: Protection step timing, PWM timebase, clock watch and retry
// Assumes: direct_input_0 and cs_n are pins; other inputs are on clock
// Notes:
// Notes on behaviour
// - Over-current timing walks seven steps, profile by two-bit select, slow default.
// - Bulb cooling walks six steps; select 00 or 11 medium, 01 fast, 10 slow.
// - External PWM clock below about 2 kHz flags a clock failure.
// - External PWM clock above about 200 kHz flags a clock failure.
// - Clock watch runs only with PWM enabled and external clock selected.
// - Uncalibrated internal oscillator gives about 120 Hz PWM.
// - Chip-select low pulse calibrates oscillator only if 20 to 200 us long.
// - Duty 0 keeps output off, full duty keeps it on, others modulate.
// - No toggle on a direct input for about 250 ms flags a timeout.
`timescale 1ns/1ps
module swp_timing #(
	parameter int TICK_CYC = swp_pkg::TICK_CYC,
	parameter int CAL_GAIN = swp_pkg::CAL_GAIN
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       direct_input_0,
	input  wire logic       cs_n,
	input  wire logic [1:0] overcurrent_profile_sel,
	input  wire logic       oc_active,
	input  wire logic [1:0] cooling_profile_sel,
	input  wire logic       bc_active,
	input  wire logic       pwm_enable,
	input  wire logic       clock_sel,
	input  wire logic [8:0] pwm_duty,
	input  wire logic       toggle_watch_en,
	input  wire logic       retry_pending,
	output logic      [2:0] oc_step,
	output logic            oc_expired,
	output logic      [2:0] bc_step,
	output logic            bc_expired,
	output logic            clock_fail,
	output logic            pwm_cal_done,
	output logic            pwm_out,
	output logic            toggle_timeout,
	output logic            retry_pulse
);
	localparam int TW     = swp_pkg::TW;
	localparam int LO_TK  = swp_pkg::CF_LO_TICKS;
	localparam int HI_CYC = swp_pkg::CF_HI_CYC;
	localparam int TOG_TK = swp_pkg::TOG_TK;
	localparam int RET_TK = swp_pkg::RETRY_TK;
	localparam int CMIN   = swp_pkg::CAL_MIN_TK;
	localparam int CMAX   = swp_pkg::CAL_MAX_TK;
	localparam int DEFCYC = swp_pkg::PWM_DEF_CYC;

	if (TICK_CYC < 1 || TICK_CYC > 65535 || CAL_GAIN < 1 || CAL_GAIN > 128) begin : g_bad
		$error("swp_timing: TICK_CYC or CAL_GAIN out of range");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers and timebase
	// ---------------------------------------------------------------
	logic [1:0]  in0_s_r, cs_s_r;
	logic        in0_prev_r, cs_prev_r;
	logic [15:0] tk_cnt_r, tk_cnt_nxt;
	logic        tick_r, tick_nxt;
	logic        in0_rise, in0_edge, cs_rise, cs_fall;

	assign in0_rise = in0_s_r[1] & ~in0_prev_r;
	assign in0_edge = in0_s_r[1] ^ in0_prev_r;
	assign cs_rise  = cs_s_r[1] & ~cs_prev_r;
	assign cs_fall  = ~cs_s_r[1] & cs_prev_r;

	always_comb begin
		tick_nxt   = (tk_cnt_r == 16'(TICK_CYC - 1));
		tk_cnt_nxt = tick_nxt ? 16'h0 : tk_cnt_r + 16'h1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in0_s_r    <= 2'h0;
			cs_s_r     <= 2'h3;
			in0_prev_r <= 1'b0;
			cs_prev_r  <= 1'b1;
			tk_cnt_r   <= 16'h0;
			tick_r     <= 1'b0;
		end else if (ce) begin
			in0_s_r    <= {in0_s_r[0], direct_input_0};
			cs_s_r     <= {cs_s_r[0], cs_n};
			in0_prev_r <= in0_s_r[1];
			cs_prev_r  <= cs_s_r[1];
			tk_cnt_r   <= tk_cnt_nxt;
			tick_r     <= tick_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Protection step timers
	// ---------------------------------------------------------------
	logic [TW-1:0] oc_len, bc_len;
	logic [2:0]    oc_idx, bc_idx;
	logic [1:0]    bc_row;

	always_comb begin
		oc_idx = (oc_step == 3'h0) ? 3'h0 : oc_step - 3'h1;
		bc_idx = (bc_step == 3'h0) ? 3'h0 : bc_step - 3'h1;
		// Select 11 shares the medium row
		bc_row = (cooling_profile_sel == 2'h3) ? 2'h0 : cooling_profile_sel;
		oc_len = TW'(swp_pkg::OC_STEP_US[overcurrent_profile_sel][oc_idx]);
		bc_len = TW'(swp_pkg::BC_STEP_US[bc_row][bc_idx]);
	end

	swp_step_timer #(.NSTEPS(swp_pkg::OC_STEPS)) u_oc (
		.clock    (clock),
		.rst      (rst),
		.ce       (ce),
		.tick     (tick_r),
		.active   (oc_active),
		.step_len (oc_len),
		.step     (oc_step),
		.expired  (oc_expired)
	);

	swp_step_timer #(.NSTEPS(swp_pkg::BC_STEPS)) u_bc (
		.clock    (clock),
		.rst      (rst),
		.ce       (ce),
		.tick     (tick_r),
		.active   (bc_active),
		.step_len (bc_len),
		.step     (bc_step),
		.expired  (bc_expired)
	);

	// ---------------------------------------------------------------
	// Clock watch, calibration, PWM, toggle watch, retry
	// ---------------------------------------------------------------
	logic        det_en, cal_win, int_adv, slot_adv;
	logic [15:0] cal_slot;
	logic [7:0]  cf_cyc_r, cf_cyc_nxt;
	logic [9:0]  cf_tk_r, cf_tk_nxt;
	logic        cf_arm_r, cf_arm_nxt, fail_r, fail_nxt;
	logic [8:0]  cal_cnt_r, cal_cnt_nxt;
	logic        cal_r, cal_nxt;
	logic [15:0] slot_len_r, slot_len_nxt, slot_cyc_r, slot_cyc_nxt;
	logic [7:0]  pcnt_r, pcnt_nxt;
	logic        pout_r, pout_nxt;
	logic [17:0] tog_r, tog_nxt, ret_r, ret_nxt;
	logic        tmo_r, tmo_nxt, rp_r, rp_nxt;

	assign det_en   = pwm_enable & ~clock_sel;
	assign cal_win  = cal_cnt_r >= 9'(CMIN) && cal_cnt_r <= 9'(CMAX);
	assign cal_slot = 16'(cal_cnt_r) * 16'(CAL_GAIN);
	assign int_adv  = slot_cyc_r >= slot_len_r - 16'h1;
	assign slot_adv = clock_sel ? int_adv : in0_rise;

	always_comb begin
		cf_cyc_nxt   = (cf_cyc_r == 8'(HI_CYC)) ? cf_cyc_r : cf_cyc_r + 8'h1;
		cf_tk_nxt    = cf_tk_r;
		cf_arm_nxt   = cf_arm_r;
		fail_nxt     = fail_r;
		cal_cnt_nxt  = cal_cnt_r;
		cal_nxt      = cal_r;
		slot_len_nxt = slot_len_r;
		slot_cyc_nxt = (!clock_sel || int_adv) ? 16'h0 : slot_cyc_r + 16'h1;
		pcnt_nxt     = slot_adv ? pcnt_r + 8'h1 : pcnt_r;
		tog_nxt      = tog_r;
		tmo_nxt      = tmo_r;
		ret_nxt      = ret_r;
		rp_nxt       = 1'b0;
		if (!det_en) begin
			cf_tk_nxt  = 10'h0;
			cf_arm_nxt = 1'b0;
			fail_nxt   = 1'b0;
		end else if (in0_rise) begin
			// First edge after enabling has no valid gap to judge
			if (cf_arm_r && cf_cyc_r < 8'(HI_CYC))
				fail_nxt = 1'b1;
			cf_cyc_nxt = 8'h0;
			cf_tk_nxt  = 10'h0;
			cf_arm_nxt = 1'b1;
		end else if (tick_r) begin
			if (cf_tk_r >= 10'(LO_TK - 1))
				fail_nxt = 1'b1;
			else
				cf_tk_nxt = cf_tk_r + 10'h1;
		end
		// Short SPI frames also drop chip select; they fall below the window
		if (cs_fall)
			cal_cnt_nxt = 9'h0;
		else if (!cs_s_r[1] && tick_r && cal_cnt_r != 9'h1ff)
			cal_cnt_nxt = cal_cnt_r + 9'h1;
		if (cs_rise && cal_win) begin
			cal_nxt      = 1'b1;
			slot_len_nxt = cal_slot;
		end
		if (!pwm_enable)
			pcnt_nxt = 8'h0;
		// Nine-bit duty lets 256 and above hold the output fully on
		pout_nxt = pwm_enable && ({1'b0, pcnt_nxt} < pwm_duty);
		if (!toggle_watch_en) begin
			tog_nxt = 18'h0;
			tmo_nxt = 1'b0;
		end else if (in0_edge) begin
			tog_nxt = 18'h0;
		end else if (tick_r) begin
			if (tog_r >= 18'(TOG_TK - 1))
				tmo_nxt = 1'b1;
			else
				tog_nxt = tog_r + 18'h1;
		end
		if (!retry_pending) begin
			ret_nxt = 18'h0;
		end else if (tick_r) begin
			if (ret_r == 18'(RET_TK - 1)) begin
				ret_nxt = 18'h0;
				rp_nxt  = 1'b1;
			end else begin
				ret_nxt = ret_r + 18'h1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cf_cyc_r   <= 8'h0;
			cf_tk_r    <= 10'h0;
			cf_arm_r   <= 1'b0;
			fail_r     <= 1'b0;
			cal_cnt_r  <= 9'h0;
			cal_r      <= 1'b0;
			slot_len_r <= 16'(DEFCYC);
			slot_cyc_r <= 16'h0;
			pcnt_r     <= 8'h0;
			pout_r     <= 1'b0;
			tog_r      <= 18'h0;
			tmo_r      <= 1'b0;
			ret_r      <= 18'h0;
			rp_r       <= 1'b0;
		end else if (ce) begin
			cf_cyc_r   <= cf_cyc_nxt;
			cf_tk_r    <= cf_tk_nxt;
			cf_arm_r   <= cf_arm_nxt;
			fail_r     <= fail_nxt;
			cal_cnt_r  <= cal_cnt_nxt;
			cal_r      <= cal_nxt;
			slot_len_r <= slot_len_nxt;
			slot_cyc_r <= slot_cyc_nxt;
			pcnt_r     <= pcnt_nxt;
			pout_r     <= pout_nxt;
			tog_r      <= tog_nxt;
			tmo_r      <= tmo_nxt;
			ret_r      <= ret_nxt;
			rp_r       <= rp_nxt;
		end
	end

	assign clock_fail     = fail_r;
	assign pwm_cal_done   = cal_r;
	assign pwm_out        = pout_r;
	assign toggle_timeout = tmo_r;
	assign retry_pulse    = rp_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_cal_good;
		ce && cs_rise && cal_win;
	endsequence
	sequence s_cal_bad;
		ce && cs_rise && !cal_win;
	endsequence

	AST_OC_DEFAULT_SLOW:
		assert property (oc_step == 3'h1 && overcurrent_profile_sel == 2'h0 |-> oc_len == TW'(5000))
		else $error("slow profile first step wrong");
	AST_BC_ELEVEN_MEDIUM:
		assert property (bc_step == 3'h1 && cooling_profile_sel == 2'h3 |-> bc_len == TW'(834000))
		else $error("cooling select 11 not medium");
	AST_CF_LOW:
		assert property (ce && det_en && tick_r && !in0_rise && cf_tk_r == 10'(LO_TK - 1)
			|=> fail_r)
		else $error("slow clock not flagged");
	AST_CF_HIGH:
		assert property (ce && det_en && in0_rise && cf_arm_r && cf_cyc_r < 8'(HI_CYC) |=> fail_r)
		else $error("fast clock not flagged");
	AST_CF_GATE:
		assert property (ce && !det_en |=> !fail_r ##1 (!fail_r || det_en || !ce))
		else $error("clock watch active while gated");
	AST_DEF_FREQ:
		assert property (ce && clock_sel && !cal_r && int_adv |-> slot_cyc_r == 16'(DEFCYC - 1))
		else $error("default slot length wrong");
	AST_CAL_TAKE:
		assert property (s_cal_good |=> cal_r && slot_len_r == $past(cal_slot))
		else $error("valid calibration pulse not taken");
	AST_CAL_REJECT:
		assert property (s_cal_bad |=> $stable(slot_len_r))
		else $error("calibration pulse outside window taken");
	AST_DUTY_ENDS:
		assert property (ce && pwm_enable && (pwm_duty == 9'h0 || pwm_duty[8])
			|=> pout_r == $past(pwm_duty[8]))
		else $error("full on or full off duty not held");
	AST_TOGGLE:
		assert property (ce && toggle_watch_en && tick_r && !in0_edge && tog_r == 18'(TOG_TK - 1)
			|=> tmo_r)
		else $error("toggle timeout missed");
	AST_RETRY:
		assert property (ce && rp_r |=> !rp_r || !ce)
		else $error("retry pulse longer than one cycle");
endmodule // swp_timing

// ===== core/swp_pkg.sv
// Purpose: Shared constants for the switch protection and PWM timing block
// Assumes: 40 MHz system clock, timebase tick of whole microseconds
// Notes:   Step tables are in microseconds of timebase tick
package swp_pkg;
	// ---------------------------------------------------------------
	// Clock and timebase
	// ---------------------------------------------------------------
	localparam int CLK_HZ   = 40_000_000;
	localparam int TICK_US  = 1;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int TW       = 21;

	// ---------------------------------------------------------------
	// Over-current and bulb-cooling step tables
	// ---------------------------------------------------------------
	localparam int OC_STEPS = 7;
	localparam int BC_STEPS = 6;
	localparam logic [1:0] OC_SEL_SLOW = 2'h0;
	localparam int OC_STEP_US [4][7] = '{
		'{5000, 1720, 2000, 3000, 5000, 12200, 44600},
		'{2480, 800, 1040, 1580, 2240, 6120, 22200},
		'{9800, 3200, 4200, 5800, 9800, 24400, 89200},
		'{19600, 6400, 8400, 11600, 19600, 48800, 178400}};
	// Rows: medium, fast, slow
	localparam int BC_STEP_US [3][6] = '{
		'{834000, 448000, 510000, 596000, 718000, 898000},
		'{418000, 224000, 254000, 290000, 360000, 648000},
		'{1668000, 894000, 1022000, 1192000, 1434000, 1796000}};

	// ---------------------------------------------------------------
	// PWM clock watch, oscillator and calibration
	// ---------------------------------------------------------------
	localparam real CF_LO_KHZ   = 2.0;
	localparam real CF_HI_KHZ   = 200.0;
	localparam int  CF_LO_TICKS = int'(1000.0 / CF_LO_KHZ) / TICK_US;
	localparam int  CF_HI_CYC   = int'(CLK_HZ / (CF_HI_KHZ * 1000.0));
	localparam int  PWM_DEF_HZ  = 120;
	localparam int  PWM_SLOTS   = 256;
	localparam int  PWM_DEF_CYC = CLK_HZ / (PWM_DEF_HZ * PWM_SLOTS);
	localparam int  CAL_MIN_US  = 20;
	localparam int  CAL_MAX_US  = 200;
	localparam int  CAL_MIN_TK  = (CAL_MIN_US + TICK_US - 1) / TICK_US;
	localparam int  CAL_MAX_TK  = CAL_MAX_US / TICK_US;
	localparam int  CAL_GAIN    = 8;

	// ---------------------------------------------------------------
	// Input watch and auto-retry
	// ---------------------------------------------------------------
	localparam int TOG_MS    = 250;
	localparam int TOG_TK    = TOG_MS * 1000 / TICK_US;
	localparam int RETRY_MS  = 150;
	localparam int RETRY_TK  = RETRY_MS * 1000 / TICK_US;
endpackage

// ===== core/swp_step_timer.sv
// Purpose: Walks a sequence of timed steps while its trigger is active
// Assumes: tick is a one-cycle pulse from the shared timebase
// Notes:   Step length is looked up outside from the current step
`timescale 1ns/1ps
module swp_step_timer #(
	parameter int NSTEPS = 7
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  ce,
	input  wire logic                  tick,
	input  wire logic                  active,
	input  wire logic [swp_pkg::TW-1:0] step_len,
	output logic      [2:0]            step,
	output logic                       expired
);
	localparam int TW = swp_pkg::TW;
	if (NSTEPS < 1 || NSTEPS > 7) begin : g_bad
		$error("swp_step_timer: NSTEPS out of range");
	end

	logic [TW-1:0] cnt_r, cnt_nxt;
	logic [2:0]    step_r, step_nxt;
	logic          exp_r, exp_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		step_nxt = step_r;
		exp_nxt  = exp_r;
		if (!active) begin
			cnt_nxt  = '0;
			step_nxt = 3'h0;
			exp_nxt  = 1'b0;
		end else if (step_r == 3'h0) begin
			step_nxt = 3'h1;
		end else if (tick && !exp_r) begin
			if (cnt_r >= step_len - TW'(1)) begin
				cnt_nxt = '0;
				if (step_r == 3'(NSTEPS))
					exp_nxt = 1'b1;
				else
					step_nxt = step_r + 3'h1;
			end else begin
				cnt_nxt = cnt_r + TW'(1);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r  <= '0;
			step_r <= 3'h0;
			exp_r  <= 1'b0;
		end else if (ce) begin
			cnt_r  <= cnt_nxt;
			step_r <= step_nxt;
			exp_r  <= exp_nxt;
		end
	end

	assign step    = step_r;
	assign expired = exp_r;

	AST_STEP_LAST:
		assert property (@(posedge clock) disable iff (rst) $rose(exp_r) |-> step_r == 3'(NSTEPS))
		else $error("step sequence ended early");
	AST_STEP_FIRST:
		assert property (@(posedge clock) disable iff (rst)
			ce && active && step_r == 3'h0 |=> step_r == 3'h1 && cnt_r == '0)
		else $error("step sequence did not start at step one");
endmodule // swp_step_timer

// ===== dv/swp_host_model.sv
// Purpose: Host side of the timing block: PWM clock pin and chip-select
// Assumes: Times are counted in system clock edges
// Notes:   Pull-down on the clock pin, pull-up on chip-select when idle
`timescale 1ns/1ps
module swp_host_model (
	input  wire logic clock,
	output logic      direct_input_0,
	output logic      cs_n
);
	// Half period in clock cycles; 0 stops the clock
	int half_cyc = 0;

	initial begin
		direct_input_0 = 1'b0;
		cs_n           = 1'b1;
	end

	// ---------------------------------------------------------------
	// External PWM clock
	// ---------------------------------------------------------------
	// Legal range is kept in scaled time; faster settings are deliberate faults
	always begin
		@(posedge clock);
		if (half_cyc > 0) begin
			repeat (half_cyc - 1) @(posedge clock);
			#1 direct_input_0 = ~direct_input_0;
		end else begin
			#1 direct_input_0 = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Calibration pulse
	// ---------------------------------------------------------------
	task automatic cal_pulse(input int w);
		@(posedge clock);
		#1 cs_n = 1'b0;
		repeat (w) @(posedge clock);
		#1 cs_n = 1'b1;
	endtask
endmodule // swp_host_model

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the protection and PWM timing block
// Assumes: Tick of one cycle, so step tables read in cycles
// Notes:   Toggle and retry spans exceed the run budget; only early firing is checked
`timescale 1ns/1ps
module testbench;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	logic       direct_input_0;
	logic       cs_n;
	logic [1:0] overcurrent_profile_sel = 2'h0;
	logic       oc_active = 1'b0;
	logic [1:0] cooling_profile_sel = 2'h0;
	logic       bc_active = 1'b0;
	logic       pwm_enable = 1'b0;
	logic       clock_sel = 1'b0;
	logic [8:0] pwm_duty = 9'h000;
	logic       toggle_watch_en = 1'b0;
	logic       retry_pending = 1'b0;
	logic [2:0] oc_step;
	logic       oc_expired;
	logic [2:0] bc_step;
	logic       bc_expired;
	logic       clock_fail;
	logic       pwm_cal_done;
	logic       pwm_out;
	logic       toggle_timeout;
	logic       retry_pulse;
	int         bad_count = 0;
	int         tests_run = 0;
	int         hi_n;
	int         lo_n;
	int         rp_n = 0;
	int         oc_len [4] = '{5000, 2480, 9800, 19600};

	always #12.5 clock = ~clock;

	// Retry pulses are one cycle wide, so count them as they pass
	always @(posedge clock) begin
		if (retry_pulse === 1'b1)
			rp_n++;
	end

	swp_timing #(.TICK_CYC(1), .CAL_GAIN(8)) dut_u (
		.clock(clock), .rst(rst), .ce(ce), .direct_input_0(direct_input_0), .cs_n(cs_n),
		.overcurrent_profile_sel(overcurrent_profile_sel), .oc_active(oc_active),
		.cooling_profile_sel(cooling_profile_sel), .bc_active(bc_active),
		.pwm_enable(pwm_enable), .clock_sel(clock_sel), .pwm_duty(pwm_duty),
		.toggle_watch_en(toggle_watch_en), .retry_pending(retry_pending),
		.oc_step(oc_step), .oc_expired(oc_expired), .bc_step(bc_step),
		.bc_expired(bc_expired), .clock_fail(clock_fail), .pwm_cal_done(pwm_cal_done),
		.pwm_out(pwm_out), .toggle_timeout(toggle_timeout), .retry_pulse(retry_pulse)
	);

	swp_host_model host_u (
		.clock(clock),
		.direct_input_0(direct_input_0),
		.cs_n(cs_n)
	);

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic count_hi(input int n, output int c);
		c = 0;
		repeat (n) begin
			cyc(1);
			if (pwm_out === 1'b1) c++;
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Whole run is about 89k cycles; margin for a slow design
	initial begin
		#(96000 * 25);
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		results();
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		cyc(6);
		rst = 1'b0;
		cyc(3);
		chk(oc_step, 0);
		// Clock watch: legal clock, stopped clock, gated, too fast
		pwm_enable = 1'b1;
		host_u.half_cyc = 200;
		cyc(3000);
		chk(clock_fail, 0);
		host_u.half_cyc = 0;
		cyc(700);
		chk(clock_fail, 1);
		clock_sel = 1'b1;
		host_u.half_cyc = 40;
		cyc(3);
		chk(clock_fail, 0);
		cyc(1000);
		chk(clock_fail, 0);
		clock_sel = 1'b0;
		cyc(300);
		chk(clock_fail, 1);
		pwm_enable = 1'b0;
		cyc(3);
		chk(clock_fail, 0);
		host_u.half_cyc = 0;
		$display("test clock_watch done");
		// Default internal slot: duty of one slot stays on for one slot length
		clock_sel = 1'b1;
		pwm_duty = 9'h001;
		pwm_enable = 1'b1;
		cyc(swp_pkg::PWM_DEF_CYC - 1);
		chk(pwm_out, 1);
		cyc(1);
		chk(pwm_out, 0);
		pwm_enable = 1'b0;
		clock_sel = 1'b0;
		cyc(3);
		$display("test default_frequency done");
		// Calibration: too short, too long, then accepted
		host_u.cal_pulse(10);
		cyc(10);
		chk(pwm_cal_done, 0);
		host_u.cal_pulse(300);
		cyc(10);
		chk(pwm_cal_done, 0);
		host_u.cal_pulse(21);
		cyc(5);
		chk(pwm_cal_done, 1);
		// Half duty on slot calibrated from the 21-cycle pulse: 20 ticks times gain
		clock_sel = 1'b1;
		pwm_duty = 9'h080;
		pwm_enable = 1'b1;
		hi_n = 0;
		lo_n = 0;
		cyc(1);
		while (pwm_out === 1'b1 && hi_n < 30000) begin
			cyc(1);
			hi_n++;
		end
		while (pwm_out === 1'b0 && lo_n < 30000) begin
			cyc(1);
			lo_n++;
		end
		chk(lo_n >= 20480 && lo_n <= 22528, 1);
		chk(hi_n + 8 >= lo_n && hi_n <= lo_n, 1);
		// Extremes stay off or on; mid range is where the host would calibrate
		pwm_duty = 9'h000;
		cyc(3);
		count_hi(2000, hi_n);
		chk(hi_n, 0);
		pwm_duty = 9'h100;
		cyc(3);
		count_hi(2000, hi_n);
		chk(hi_n, 2000);
		pwm_enable = 1'b0;
		$display("test calibration_pwm done");
		// Bulb cooling starts for every selector code
		for (int p = 0; p < 4; p++) begin
			cooling_profile_sel = p[1:0];
			bc_active = 1'b1;
			cyc(3);
			chk(bc_step, 1);
			chk(bc_expired, 0);
			bc_active = 1'b0;
			cyc(2);
			chk(bc_step, 0);
		end
		$display("test bulb_cooling done");
		// First over-current step length per profile; toggle and retry watches armed meanwhile
		toggle_watch_en = 1'b1;
		retry_pending = 1'b1;
		for (int p = 0; p < 4; p++) begin
			overcurrent_profile_sel = p[1:0];
			oc_active = 1'b1;
			cyc(oc_len[p] - 20);
			chk(oc_step, 1);
			cyc(40);
			chk(oc_step, 2);
			chk(oc_expired, 0);
			oc_active = 1'b0;
			cyc(2);
			chk(oc_step, 0);
		end
		chk(toggle_timeout, 0);
		chk(rp_n, 0);
		toggle_watch_en = 1'b0;
		retry_pending = 1'b0;
		$display("test overcurrent done");
		results();
	end
endmodule // testbench
